// file: codec_irq_fifo_service.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// How it works
// - Address-ready flag: host clears, set wins
// - Reading status drops the host interrupt, a new masked event wins
// - Line code holds until one long word read
// - Line code rises only on FIFO read
module codec_irq_fifo_service (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic encode_mode_in,         // 1 encode, 0 decode
  input wire logic [15:0] enc_word_in,     // Compressed word from core
  input wire logic enc_field_end_in,       // Word is last of the field
  input wire logic enc_word_valid_in,      // Core word strobe
  input wire logic fifo_rd_in,             // Host reads one FIFO word
  input wire logic fifo_wr_in,             // Host writes one FIFO word
  input wire logic [15:0] fifo_wr_data_in, // Host write data
  input wire logic dec_ready_in,           // Decode core takes a word
  input wire logic statistics_ready_in,    // Core statistics event
  input wire logic mem_err_in,             // Memory fault event
  input wire logic video_stream_fault_in,  // Video stream fault event
  input wire logic fifo_stop_in,           // Core halted FIFO event
  input wire logic [6:0] irq_mask_in,      // Interrupt mask
  input wire logic stat_rd_in,             // Host reads mask and status
  input wire logic ready_clr_in,           // Host hands buffer back
  input wire logic qt_wr_in,               // Quantizer table write
  input wire logic [6:0] qt_addr_in,       // Quantizer table index
  input wire logic [15:0] qt_data_in,      // Quantizer table data
  output logic [15:0] fifo_rd_data_out,    // Word read by host
  output logic [6:0] stat_rd_data_out,     // Status word read by host
  output logic host_interrupt_request_n_out, // Host interrupt, low active
  output logic line_code_out,              // Line-code indication
  output logic fifo_service_request_out,   // FIFO needs service
  output logic ready_new_addr_out,         // Ready-for-new-address flag
  output logic [15:0] dec_word_out,        // Word to decode core
  output logic dec_word_valid_out,         // Decode word strobe
  output logic [15:0] qt_rd_data_out       // Table entry just written
);
  ////////////////////////////////////////////////////////////////////////
  // Declarations
  codec_pkg::fifo_entry_s push_data; // Entry into FIFO
  codec_pkg::fifo_entry_s pop_data;  // Entry at FIFO head
  logic push, pop; // FIFO push and pop requests
  logic full, empty; // FIFO full and empty
  logic [6:0] count; // FIFO fill
  logic host_pop, dec_pop; // Host read or decode core takes a word
  logic overflow, underflow; // Push into full, read from empty FIFO
  logic lc_set, lc_clear; // Line code raises or drops this cycle
  logic srq_level;       // Service level reached
  logic [6:0] events;    // Sticky event sets this cycle
  logic [6:0] status;    // Live status word
  logic line_code_q;     // Line-code indication
  logic lc_half_q;       // Half of clearing long word read
  logic srq_q;           // Registered service request
  logic [6:0] sticky_q;  // Sticky event bits
  logic irq_q;           // Interrupt pending
  logic ready_q;         // Ready-for-new-address flag
  logic [15:0] rd_data_q, dec_word_q, qt_rd_q; // Data output registers
  logic [6:0] stat_rd_q; // Status read register
  logic dec_valid_q; // Decode word strobe register
  logic [15:0] qt_mem_q [codec_pkg::QT_ENTRIES]; // Quantizer width table

  // True for an index inside the quantizer width table
  function automatic logic qt_index_ok(input logic [6:0] idx);
    qt_index_ok = (32'(idx) < codec_pkg::QT_ENTRIES);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // FIFO and its two directions
  assign host_pop = fifo_rd_in && encode_mode_in && !empty;
  assign dec_pop = dec_ready_in && !encode_mode_in && !empty;
  assign pop = host_pop || dec_pop;
  assign push = encode_mode_in ? enc_word_valid_in : fifo_wr_in;
  assign push_data.word = encode_mode_in ? enc_word_in : fifo_wr_data_in;
  assign push_data.field_end = encode_mode_in && enc_field_end_in;
  assign overflow = push && full;
  assign underflow = (fifo_rd_in && encode_mode_in && empty) ||
                     (dec_ready_in && !encode_mode_in && empty);

  codec_word_fifo u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .push_in(push),
    .push_data_in(push_data),
    .pop_in(pop),
    .pop_data_out(pop_data),
    .full_out(full),
    .empty_out(empty),
    .count_out(count)
  );

  // Encode wants draining at or above the level, decode wants filling at or below it
  assign srq_level = encode_mode_in ? (count >= codec_pkg::SRQ_LEVEL) :
                     (count <= codec_pkg::FIFO_FULL - codec_pkg::SRQ_LEVEL);

  // Host read data and decode output words
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_q <= 16'h0000;
      dec_word_q <= 16'h0000;
      dec_valid_q <= 1'b0;
    end else begin
      if (host_pop) begin
        rd_data_q <= pop_data.word;
      end
      if (dec_pop) begin
        dec_word_q <= pop_data.word;
      end
      dec_valid_q <= dec_pop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line code: raised by reading the field's last word, held until the
  // following long word (two host reads) has left the FIFO
  assign lc_set = host_pop && pop_data.field_end;
  assign lc_clear = line_code_q && host_pop && lc_half_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      line_code_q <= 1'b0;
      lc_half_q <= 1'b0;
    end else if (lc_set) begin
      line_code_q <= 1'b1;
      lc_half_q <= 1'b0;
    end else if (lc_clear) begin
      line_code_q <= 1'b0;
      lc_half_q <= 1'b0;
    end else if (line_code_q && host_pop) begin
      lc_half_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status and interrupt
  always_comb begin
    events = codec_pkg::ST_RESET;
    events[codec_pkg::ST_LINE_CODE] = lc_set;
    events[codec_pkg::ST_STATS] = statistics_ready_in;
    events[codec_pkg::ST_SRQ] = srq_level && !srq_q;
    events[codec_pkg::ST_MEM_ERR] = mem_err_in;
    events[codec_pkg::ST_FIFO_ERR] = overflow || underflow;
    events[codec_pkg::ST_FIFO_STOP] = fifo_stop_in;
    events[codec_pkg::ST_VIDEO_FAULT] = video_stream_fault_in;
  end

  // Levels report live, events report their sticky bit
  always_comb begin
    status = sticky_q;
    status[codec_pkg::ST_LINE_CODE] = line_code_q;
    status[codec_pkg::ST_SRQ] = srq_q;
  end

  // Sticky bits clear on status read; a new event wins the clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sticky_q <= codec_pkg::ST_RESET;
      srq_q <= 1'b0;
    end else begin
      sticky_q <= (stat_rd_in ? codec_pkg::ST_RESET : sticky_q) | events;
      srq_q <= srq_level;
    end
  end

  // Read returns the masked status and drops the interrupt; a new masked event wins the drop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stat_rd_q <= codec_pkg::ST_RESET;
      irq_q <= 1'b0;
    end else begin
      if (stat_rd_in) begin
        stat_rd_q <= status & irq_mask_in & codec_pkg::MASK_ALL;
      end
      if ((events & irq_mask_in) != 7'h00) begin
        irq_q <= 1'b1;
      end else if (stat_rd_in) begin
        irq_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ready-for-new-address flag: set when the long word after the field end has been read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ready_q <= 1'b0;
    end else if (lc_clear) begin
      ready_q <= 1'b1;
    end else if (ready_clr_in) begin
      ready_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Quantizer width table, block-written by the host
  always_ff @(posedge clk_in) begin
    if (qt_wr_in && qt_index_ok(qt_addr_in)) begin
      qt_mem_q[qt_addr_in] <= qt_data_in;
    end
  end

  // Echo of the last accepted table write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      qt_rd_q <= 16'h0000;
    end else if (qt_wr_in && qt_index_ok(qt_addr_in)) begin
      qt_rd_q <= qt_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign fifo_rd_data_out = rd_data_q;
  assign stat_rd_data_out = stat_rd_q;
  assign host_interrupt_request_n_out = !irq_q;
  assign line_code_out = line_code_q;
  assign fifo_service_request_out = srq_q;
  assign ready_new_addr_out = ready_q;
  assign dec_word_out = dec_word_q;
  assign dec_word_valid_out = dec_valid_q;
  assign qt_rd_data_out = qt_rd_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_lc_rise;
    @(posedge clk_in) disable iff (rst_in)
    $rose(line_code_q) |-> $past(host_pop) && $past(pop_data.field_end);
  endproperty
  a_lc_rise: assert property (p_lc_rise)
    else $error("line code rose without a field-end read");
  property p_lc_hold;
    @(posedge clk_in) disable iff (rst_in)
    $fell(line_code_q) |-> $past(host_pop) && $past(lc_half_q);
  endproperty
  a_lc_hold: assert property (p_lc_hold)
    else $error("line code fell before a long word was read");
  property p_lc_two_reads;
    @(posedge clk_in) disable iff (rst_in)
    lc_set ##1 (!host_pop && !lc_set)[*2] |-> line_code_q;
  endproperty
  a_lc_two_reads: assert property (p_lc_two_reads)
    else $error("line code dropped with no reads");
  property p_irq_drop;
    @(posedge clk_in) disable iff (rst_in)
    stat_rd_in && ((events & irq_mask_in) == 7'h00) |=>
      host_interrupt_request_n_out;
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("interrupt still asserted after status read");
  property p_irq_raise;
    @(posedge clk_in) disable iff (rst_in)
    ((events & irq_mask_in) != 7'h00) |=> !host_interrupt_request_n_out;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("masked event did not raise the interrupt");
  property p_ready_set_wins;
    @(posedge clk_in) disable iff (rst_in)
    lc_clear |=> ready_new_addr_out;
  endproperty
  a_ready_set_wins: assert property (p_ready_set_wins)
    else $error("address-ready flag not set at field end");
  property p_ready_clear;
    @(posedge clk_in) disable iff (rst_in)
    ready_clr_in && !lc_clear |=> !ready_new_addr_out;
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("address-ready flag not cleared by host");
  property p_read_word;
    @(posedge clk_in) disable iff (rst_in)
    host_pop |=> fifo_rd_data_out == $past(pop_data.word);
  endproperty
  a_read_word: assert property (p_read_word)
    else $error("host read returned the wrong word");
  c_field_end: cover property (@(posedge clk_in) disable iff (rst_in)
    lc_set ##[1:20] lc_clear);
  c_status_read: cover property (@(posedge clk_in) disable iff (rst_in)
    !host_interrupt_request_n_out ##1 stat_rd_in);
  c_decode_word: cover property (@(posedge clk_in) disable iff (rst_in)
    !encode_mode_in && dec_valid_q);
endmodule // codec_irq_fifo_service

// file: codec_word_fifo.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Shared constants and carriers for the codec host-side logic
package codec_pkg;
  localparam int WORD_W = 16;                  // Compressed data word
  localparam int FIFO_DEPTH = 64;              // Compressed FIFO words
  localparam int CNT_W = 7;                    // Fill count width
  localparam logic [6:0] SRQ_LEVEL = 7'h20;    // Service request level
  localparam logic [6:0] FIFO_FULL = 7'h40;    // Count when full
  localparam int QT_ENTRIES = 84;              // Quantizer width table size
  localparam int QT_AW = 7;                    // Table address width
  localparam int ST_W = 7;                     // Status register width
  localparam int ST_LINE_CODE = 0;             // Status bit positions
  localparam int ST_STATS = 1;
  localparam int ST_SRQ = 2;
  localparam int ST_MEM_ERR = 3;
  localparam int ST_FIFO_ERR = 4;
  localparam int ST_FIFO_STOP = 5;
  localparam int ST_VIDEO_FAULT = 6;
  localparam logic [6:0] ST_RESET = 7'h00;     // Status reset value
  localparam logic [6:0] MASK_ALL = 7'h7F;     // Mask of defined bits
  // FIFO entry: data word plus end-of-field mark
  typedef struct packed {
    logic field_end;
    logic [15:0] word;
  } fifo_entry_s;
endpackage

////////////////////////////////////////////////////////////////////////////
// Synchronous word FIFO; honest full and empty, count of held words
module codec_word_fifo (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic push_in,
  input wire codec_pkg::fifo_entry_s push_data_in,
  input wire logic pop_in,
  output codec_pkg::fifo_entry_s pop_data_out,
  output logic full_out,
  output logic empty_out,
  output logic [6:0] count_out
);
  codec_pkg::fifo_entry_s mem_q [codec_pkg::FIFO_DEPTH]; // Storage
  logic [5:0] wr_ptr_q; // Write pointer
  logic [5:0] rd_ptr_q; // Read pointer
  logic [6:0] count_q;  // Words held
  logic do_push;        // Accepted push
  logic do_pop;         // Accepted pop

  assign full_out = (count_q == codec_pkg::FIFO_FULL);
  assign empty_out = (count_q == 7'h00);
  assign count_out = count_q;
  assign pop_data_out = mem_q[rd_ptr_q];
  assign do_push = push_in && !full_out;
  assign do_pop = pop_in && !empty_out;

  // Storage write, no reset needed on data
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= push_data_in;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= 6'h00;
      rd_ptr_q <= 6'h00;
      count_q <= 7'h00;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 6'h01;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 6'h01;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 7'h01;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 7'h01;
      end
    end
  end
endmodule // codec_word_fifo

// file: host_service_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Host controller model: answers the interrupt and drains the FIFO
module host_service_model (
  input wire logic clk_in,
  input wire logic enable_in,
  input wire logic host_interrupt_request_n_in,
  input wire logic [6:0] stat_rd_data_in,
  input wire logic line_code_in,
  input wire logic ready_new_addr_in,
  input wire logic [15:0] fifo_rd_data_in,
  output logic stat_rd_out,
  output logic fifo_rd_out,
  output logic ready_clr_out,
  output logic [7:0] words_out,
  output logic [15:0] last_word_out,
  output logic eof_out,
  output logic done_out,
  output logic [7:0] faults_out
);
  localparam int PASS_LIMIT = 8; // Passes before a forced exit
  localparam int DRAIN_LEN = 64; // Counted reads per drain at most; a line code adds two more
  logic [6:0] status;            // Last status word read
  int passes;                    // Service pass counter
  int budget;                    // Drain transfer counter
  logic fault; // Status shows an error condition
  ////////////////////////////////////////////////////////////////////////////
  // One clock edge
  task automatic tick();
    @(posedge clk_in);
  endtask
  // Read one word; the request stands over exactly one edge
  task automatic read_word();
    fifo_rd_out <= 1'b1;
    tick();
    fifo_rd_out <= 1'b0;
    tick();
    last_word_out = fifo_rd_data_in;
    words_out = words_out + 8'h01;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Service loop, entered on a low interrupt
  initial begin
    stat_rd_out = 1'b0;
    fifo_rd_out = 1'b0;
    ready_clr_out = 1'b0;
    words_out = 8'h00;
    last_word_out = 16'h0000;
    eof_out = 1'b0;
    done_out = 1'b0;
    faults_out = 8'h00;
    forever begin
      tick();
      if (enable_in && host_interrupt_request_n_in === 1'b0) begin
        passes = 0;
        do begin
          // Read mask and status
          stat_rd_out <= 1'b1;
          tick();
          stat_rd_out <= 1'b0;
          tick();
          status = stat_rd_data_in;
          passes++;
          // Count error conditions; only a memory error would reinit
          fault = status[codec_pkg::ST_MEM_ERR] ||
                  status[codec_pkg::ST_FIFO_ERR] ||
                  status[codec_pkg::ST_VIDEO_FAULT];
          if (fault) begin
            faults_out <= faults_out + 8'h01;
          end
          // Stale line code first: one long word clears it
          if (status[codec_pkg::ST_LINE_CODE]) begin
            read_word();
            read_word();
          end
          // FIFO service: drain until counter ends or line code
          if (status[codec_pkg::ST_SRQ]) begin
            budget = DRAIN_LEN;
            while (budget > 0) begin
              read_word();
              budget--;
              // Line code cuts the drain short
              if (line_code_in === 1'b1) begin
                budget = 0;
                eof_out = 1'b1;
                // The long word after the field end opens the next field
                read_word();
                read_word();
              end
            end
          end
        end while (status !== 7'h00 && passes < PASS_LIMIT);
        // End of field: hand the new buffer back once it is offered
        if (eof_out && ready_new_addr_in === 1'b1) begin
          ready_clr_out <= 1'b1;
          tick();
          ready_clr_out <= 1'b0;
        end
        done_out <= 1'b1;
      end
    end
  end
endmodule // host_service_model

// file: tb.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the codec device block
module tb;
  logic clk_in, rst_in, encode_mode_in, enc_field_end_in, enc_word_valid_in;
  logic fifo_wr_in, dec_ready_in, qt_wr_in, stat_rd_in, fifo_rd_in;
  logic [15:0] enc_word_in, fifo_wr_data_in, qt_data_in;
  logic [6:0] irq_mask_in, qt_addr_in, st;
  logic [3:0] ev; // Event pulses
  logic statistics_ready_in, mem_err_in, video_stream_fault_in, fifo_stop_in;
  logic ready_clr_in, tb_srd, tb_frd, tb_clr, m_en, m_srd, m_frd, m_clr;
  logic m_eof, m_done;
  logic [7:0] m_words, m_faults;
  logic [15:0] m_last, fifo_rd_data_out, dec_word_out, qt_rd_data_out;
  logic [6:0] stat_rd_data_out;
  logic host_interrupt_request_n_out, line_code_out, fifo_service_request_out;
  logic ready_new_addr_out, dec_word_valid_out;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Bench and model share the host request inputs
  assign stat_rd_in = tb_srd | m_srd;
  assign fifo_rd_in = tb_frd | m_frd;
  assign ready_clr_in = tb_clr | m_clr;
  assign {fifo_stop_in, video_stream_fault_in, mem_err_in} = ev[3:1];
  assign statistics_ready_in = ev[0];
  codec_irq_fifo_service u_codec_irq_fifo_service (
    .clk_in, .rst_in, .encode_mode_in, .enc_word_in, .enc_field_end_in,
    .enc_word_valid_in, .fifo_rd_in, .fifo_wr_in, .fifo_wr_data_in,
    .dec_ready_in, .statistics_ready_in, .mem_err_in, .video_stream_fault_in,
    .fifo_stop_in, .irq_mask_in, .stat_rd_in, .ready_clr_in, .qt_wr_in,
    .qt_addr_in, .qt_data_in, .fifo_rd_data_out, .stat_rd_data_out,
    .host_interrupt_request_n_out, .line_code_out, .fifo_service_request_out,
    .ready_new_addr_out, .dec_word_out, .dec_word_valid_out, .qt_rd_data_out
  );
  host_service_model u_host_service_model (
    .clk_in, .enable_in(m_en), .host_interrupt_request_n_in(
    host_interrupt_request_n_out), .stat_rd_data_in(stat_rd_data_out),
    .line_code_in(line_code_out), .ready_new_addr_in(ready_new_addr_out),
    .fifo_rd_data_in(fifo_rd_data_out), .stat_rd_out(m_srd),
    .fifo_rd_out(m_frd), .ready_clr_out(m_clr), .words_out(m_words),
    .last_word_out(m_last), .eof_out(m_eof), .done_out(m_done),
    .faults_out(m_faults)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Host status read; value is settled two edges on
  task automatic rd_stat(output logic [6:0] v);
    tb_srd <= 1'b1;
    tick(1);
    tb_srd <= 1'b0;
    tick(1);
    v = stat_rd_data_out;
  endtask
  task automatic rd_word();
    tb_frd <= 1'b1;
    tick(1);
    tb_frd <= 1'b0;
    tick(1);
  endtask
  // One core word into the FIFO
  task automatic push(input logic [15:0] w, input logic e);
    enc_word_in <= w;
    enc_field_end_in <= e;
    enc_word_valid_in <= 1'b1;
    tick(1);
    enc_word_valid_in <= 1'b0;
    tick(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Each sticky event raises the interrupt; a status read drops it
  task automatic t_events();
    int pos [5] = '{codec_pkg::ST_STATS, codec_pkg::ST_MEM_ERR,
      codec_pkg::ST_VIDEO_FAULT, codec_pkg::ST_FIFO_STOP,
      codec_pkg::ST_FIFO_ERR};
    irq_mask_in <= codec_pkg::MASK_ALL;
    for (int i = 0; i < 5; i++) begin
      if (i < 4) begin
        ev <= 4'h1 << i;
        tick(1);
        ev <= 4'h0;
        tick(3);
      end else begin
        // Read from the empty FIFO raises the FIFO error
        rd_word();
        tick(2);
      end
      check("irq set", 16'(host_interrupt_request_n_out), 16'h0000);
      rd_stat(st);
      check("status", 16'(st), 16'(7'h01 << pos[i]));
      check("irq drop", 16'(host_interrupt_request_n_out), 16'h0001);
      rd_stat(st);
      check("sticky", 16'(st), 16'h0000);
    end
    irq_mask_in <= 7'h00;
    ev <= 4'h1;
    tick(1);
    ev <= 4'h0;
    tick(3);
    check("masked", 16'(host_interrupt_request_n_out), 16'h0001);
    rd_stat(st);
  endtask
  // Line code rises on the tagged read, falls after one long word
  task automatic t_line_code();
    push(16'h1111, 1'b0);
    push(16'h2222, 1'b1);
    push(16'h3333, 1'b0);
    push(16'h4444, 1'b0);
    check("lc idle", 16'(line_code_out), 16'h0000);
    rd_word();
    check("word", fifo_rd_data_out, 16'h1111);
    check("lc early", 16'(line_code_out), 16'h0000);
    rd_word();
    check("lc rise", 16'(line_code_out), 16'h0001);
    rd_word();
    check("lc hold", 16'(line_code_out), 16'h0001);
    check("rdy early", 16'(ready_new_addr_out), 16'h0000);
    rd_word();
    check("lc fall", 16'(line_code_out), 16'h0000);
    check("rdy set", 16'(ready_new_addr_out), 16'h0001);
    tb_clr <= 1'b1;
    tick(1);
    tb_clr <= 1'b0;
    tick(1);
    check("rdy clr", 16'(ready_new_addr_out), 16'h0000);
  endtask
  // Table echo, out-of-range index ignored; one decode word
  task automatic t_table_decode();
    qt_wr_in <= 1'b1;
    qt_addr_in <= 7'h53;
    qt_data_in <= 16'hBEEF;
    tick(1);
    qt_addr_in <= 7'h54;
    qt_data_in <= 16'h1234;
    tick(1);
    qt_wr_in <= 1'b0;
    tick(1);
    check("table", qt_rd_data_out, 16'hBEEF);
    encode_mode_in <= 1'b0;
    fifo_wr_data_in <= 16'hCAFE;
    fifo_wr_in <= 1'b1;
    tick(1);
    fifo_wr_in <= 1'b0;
    dec_ready_in <= 1'b1;
    tick(1);
    dec_ready_in <= 1'b0;
    tick(1);
    check("dec valid", 16'(dec_word_valid_out), 16'h0001);
    check("dec word", dec_word_out, 16'hCAFE);
    check("dec srq", 16'(fifo_service_request_out), 16'h0001);
    encode_mode_in <= 1'b1;
    tick(2);
  endtask
  // Host model services a whole field through the interrupt
  task automatic t_model();
    int n = 0;
    irq_mask_in <= codec_pkg::MASK_ALL;
    for (int i = 0; i < 42; i++) push(16'hA000 + 16'(i), i == 39);
    check("srq", 16'(fifo_service_request_out), 16'h0001);
    ev <= 4'h2; // Memory error pending beside the service request
    tick(1);
    ev <= 4'h0;
    m_en <= 1'b1;
    while (m_done !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    check("done", 16'(m_done), 16'h0001);
    tick(2);
    check("faults", 16'(m_faults), 16'h0001);
    check("words", 16'(m_words), 16'h002A);
    check("last", m_last, 16'hA029);
    check("eof", 16'(m_eof), 16'h0001);
    check("irq idle", 16'(host_interrupt_request_n_out), 16'h0001);
    check("rdy back", 16'(ready_new_addr_out), 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_in, encode_mode_in} = 2'b11;
    {enc_field_end_in, enc_word_valid_in, fifo_wr_in, dec_ready_in} = 4'h0;
    {qt_wr_in, tb_srd, tb_frd, tb_clr, m_en} = 5'h00;
    {enc_word_in, fifo_wr_data_in, qt_data_in} = 48'h0;
    {irq_mask_in, qt_addr_in, ev} = 18'h0;
    tick(3);
    rst_in <= 1'b0;
    tick(1);
    check("irq rst", 16'(host_interrupt_request_n_out), 16'h0001);
    check("rdy rst", 16'(ready_new_addr_out), 16'h0000);
    t_events();
    t_line_code();
    t_table_decode();
    t_model();
    wrap_up();
  end
endmodule // tb
